//--- verilog/asr_readout.sv
// Purpose: Serial conversion readout and select-driven power control
// Assumes: Serial clock well below mclk/4; both pins synchronised here
// Notes:   Converter results arrive as a stream through a 16-word FIFO
`timescale 1ns/1ps
module asr_readout
  import asr_pkg::*;
#(
  parameter int RES_W = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // Serial link pins
  input  wire logic             sclk_pin,
  input  wire logic             sel_n_pin,
  output logic                  serial_out_line,
  output logic                  serial_out_line_oe,
  // Converter side
  input  wire logic [RES_W-1:0] conv_data,
  input  wire logic             conv_valid,
  output logic                  conv_ready,
  output logic                  conv_start,
  output logic                  conv_abort,
  // Analog control and FIFO overflow flag
  output logic                  hold,
  output logic                  power_down,
  output logic                  fifo_overflow
);
  asr_fifo_if #(.W(RES_W)) fin ();
  asr_fifo_if #(.W(RES_W)) fout ();
  localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

  logic [2:0]       sclk_sync_reg;
  logic [2:0]       sel_sync_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [RES_W-1:0] shift_reg;
  logic             sout_reg;
  logic             oe_reg;
  logic             hold_reg;
  logic             pd_reg;
  logic             waking_reg;
  logic             start_reg;
  logic             abort_reg;
  logic             ovf_reg;
  asr_state_t       st_reg;
  logic [LVL_W-1:0] lvl_reg;

  // Edges of a synchronised pin, read from its settled stages only
  function automatic logic edge_fall(input logic [2:0] s);
    return s[2] & ~s[1];
  endfunction

  function automatic logic edge_rise(input logic [2:0] s);
    return ~s[2] & s[1];
  endfunction

  // Stage 0 feeds only stage 1; edges use stages 1 and 2
  wire sclk_fall = edge_fall(sclk_sync_reg);
  wire sclk_rise = edge_rise(sclk_sync_reg);
  wire sel_fall  = edge_fall(sel_sync_reg);
  wire sel_rise  = edge_rise(sel_sync_reg);
  wire active    = (st_reg != ST_IDLE);
  wire [CNT_W-1:0] cnt_inc = cnt_reg + 5'h01;
  wire end_frame = active && sclk_fall && (cnt_inc == LAST_EDGE);
  wire pd_win    = (cnt_reg >= PD_LO_EDGE) && (cnt_reg < PD_HI_EDGE);
  wire data_edge = (cnt_inc >= 5'(LEAD_ZEROS)) && (cnt_inc < 5'(LEAD_ZEROS + RES_BITS));
  wire load_edge = (cnt_inc == 5'(LEAD_ZEROS - 1));

  // Result words flow through the FIFO; the core only pops at the data point
  assign fin.valid  = conv_valid && conv_ready;
  assign fin.data   = conv_data;
  assign fout.ready = active && sclk_fall && load_edge;

  // Own fill count lets conv_ready leave a flop and still match the FIFO's full flag
  wire             push     = fin.valid && fin.ready;
  wire             pop      = fout.ready && fout.valid;
  wire [LVL_W-1:0] lvl_next = lvl_reg + LVL_W'(push) - LVL_W'(pop);
  wire             rdy_next = (lvl_next != LVL_W'(FIFO_DEPTH));

  asr_fifo #(.W(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk   (mclk),
    .resetn (resetn),
    .wr     (fin),
    .rd     (fout)
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      // Idle levels, so leaving reset shows no false edge
      sclk_sync_reg <= 3'h7;
      sel_sync_reg  <= 3'h7;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_pin};
      sel_sync_reg  <= {sel_sync_reg[1:0], sel_n_pin};
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lvl_reg <= '0;
    end else begin
      lvl_reg <= lvl_next;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_reg     <= ST_IDLE;
      cnt_reg    <= CNT_RST;
      shift_reg  <= '0;
      sout_reg   <= 1'b0;
      oe_reg     <= 1'b0;
      hold_reg   <= 1'b0;
      pd_reg     <= 1'b0;
      waking_reg <= 1'b0;
      start_reg  <= 1'b0;
      abort_reg  <= 1'b0;
      ovf_reg    <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      abort_reg <= 1'b0;
      ovf_reg   <= conv_valid && !conv_ready;
      case (st_reg)
        ST_IDLE: begin
          if (sel_fall) begin
            st_reg     <= ST_CONV;
            cnt_reg    <= CNT_RST;
            hold_reg   <= 1'b1;
            // A wake frame is a dummy; no conversion starts while down
            start_reg  <= ~pd_reg;
            oe_reg     <= 1'b1;
            sout_reg   <= 1'b0;
            waking_reg <= pd_reg;
          end
        end
        ST_CONV, ST_DONE: begin
          if (sel_rise) begin
            st_reg    <= ST_IDLE;
            oe_reg    <= 1'b0;
            hold_reg  <= 1'b0;
            // A rise after the last data bit is a normal end, not an abort
            abort_reg <= (cnt_reg < CONV_EDGE);
            // Early glitch keeps mode; a wake attempt ended before PD_HI_EDGE stays down, a later one wakes
            if (waking_reg) begin
              pd_reg <= (cnt_reg < PD_HI_EDGE);
            end else if (pd_win) begin
              pd_reg <= 1'b1;
            end
          end else begin
            if (sclk_fall) begin
              // Count wraps after 32 clocks; the line is released long before
              cnt_reg <= cnt_inc;
              if (load_edge) begin
                shift_reg <= fout.valid ? fout.data : '0;
                sout_reg  <= 1'b0;
              end else if (data_edge) begin
                sout_reg  <= shift_reg[RES_W-1];
                shift_reg <= {shift_reg[RES_W-2:0], 1'b0};
              end else begin
                sout_reg  <= 1'b0;
              end
              if (waking_reg && cnt_inc == WAKE_EDGE) begin
                pd_reg     <= 1'b0;
                waking_reg <= 1'b0;
              end
              if (end_frame) begin
                oe_reg <= 1'b0;
                st_reg <= ST_DONE;
              end
            end
            if (sclk_rise && cnt_reg >= TRACK_EDGE) begin
              hold_reg <= 1'b0;
            end
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // Every top output leaves a flop, so pins see no decode glitches
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      serial_out_line    <= 1'b0;
      serial_out_line_oe <= 1'b0;
      conv_ready         <= 1'b0;
      hold               <= 1'b0;
      power_down         <= 1'b0;
      conv_start         <= 1'b0;
      conv_abort         <= 1'b0;
      fifo_overflow      <= 1'b0;
    end else begin
      serial_out_line    <= sout_reg;
      conv_ready         <= rdy_next;
      serial_out_line_oe <= oe_reg;
      hold               <= hold_reg;
      power_down         <= pd_reg;
      conv_start         <= start_reg;
      conv_abort         <= abort_reg;
      fifo_overflow      <= ovf_reg;
    end
  end
endmodule

//--- verilog/asr_pkg.sv
// Purpose: Shared constants for the serial readout and power control block
// Assumes: Serial clock and select are sampled on mclk
// Notes:   Edge counts are serial clock falling edges since select fell
package asr_pkg;
  localparam int RES_BITS        = 16;
  localparam int LEAD_ZEROS      = 4;
  localparam int FRAME_BITS      = 24;
  localparam int CNT_W           = 5;
  localparam logic [CNT_W-1:0] TRACK_EDGE = 5'h11;
  localparam logic [CNT_W-1:0] LAST_EDGE  = 5'h18;
  localparam logic [CNT_W-1:0] PD_LO_EDGE = 5'h02;
  localparam logic [CNT_W-1:0] PD_HI_EDGE = 5'h0a;
  localparam logic [CNT_W-1:0] CONV_EDGE  = 5'h14;
  localparam logic [CNT_W-1:0] WAKE_EDGE  = 5'h10;
  localparam int FIFO_DEPTH      = 16;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
  typedef enum {ST_IDLE, ST_CONV, ST_DONE} asr_state_t;
endpackage

//--- verilog/asr_fifo_if.sv
// Purpose: Stream carrier between the readout core and the sample FIFO
// Assumes: One clock domain, mclk
// Notes:   valid/ready handshake, a word moves when both are high
`timescale 1ns/1ps
interface asr_fifo_if #(parameter int W = 16);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src  (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

//--- verilog/asr_fifo.sv
// Purpose: Sample FIFO between converter core and readout shifter
// Assumes: DEPTH is a power of two
// Notes:   Full holds off the writer; empty holds off the reader
`timescale 1ns/1ps
module asr_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Write side
  asr_fifo_if.sink  wr,
  // Read side
  asr_fifo_if.src   rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp_reg;
  logic [AW:0]  rp_reg;
  wire          full  = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  wire          empty = (wp_reg == rp_reg);
  wire          do_wr = wr.valid && !full;
  wire          do_rd = rd.ready && !empty;
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rp_reg[AW-1:0]];
  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem[wp_reg[AW-1:0]] <= wr.data;
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_reg + (AW+1)'(do_wr);
      rp_reg <= rp_reg + (AW+1)'(do_rd);
    end
  end
endmodule

//--- sim/asr_readout_properties.sv
// Purpose: Port-level timing checks for the readout block
// Assumes: Pin events show at outputs within 8 mclk
// Notes:   Pins are async, so delays use ranges
`timescale 1ns/1ps
module asr_readout_properties #(parameter int RES_W = 16) (
  // Clock and reset
  input wire logic             mclk,
  input wire logic             resetn,
  // Link
  input wire logic             sclk_pin,
  input wire logic             sel_n_pin,
  input wire logic             serial_out_line,
  input wire logic             serial_out_line_oe,
  // Converter and control
  input wire logic [RES_W-1:0] conv_data,
  input wire logic             conv_valid,
  input wire logic             conv_ready,
  input wire logic             conv_start,
  input wire logic             conv_abort,
  input wire logic             hold,
  input wire logic             power_down,
  input wire logic             fifo_overflow
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_sel_fall_drive: assert property (
    $fell(sel_n_pin) |-> ##[2:8] serial_out_line_oe && !serial_out_line)
    else $error("line not driven low after select fell");
  a_start_once: assert property (
    conv_start |-> !power_down && !sel_n_pin ##1 !conv_start)
    else $error("bad conversion start pulse");
  a_rise_release: assert property (
    $rose(sel_n_pin) |-> ##[2:8] !serial_out_line_oe)
    else $error("line still driven after select rose");
  a_idle_quiet: assert property (
    sel_n_pin [*8] |-> !serial_out_line_oe && !hold)
    else $error("driven or holding while idle");
  a_abort_pulse: assert property (
    conv_abort |-> sel_n_pin ##1 !conv_abort)
    else $error("bad abort pulse");
  a_pd_entry: assert property (
    $rose(power_down) |-> sel_n_pin)
    else $error("power down entered inside a frame");
  a_pd_exit: assert property (
    $fell(power_down) |-> !sel_n_pin)
    else $error("power up outside a frame");
  a_overflow_cause: assert property (
    fifo_overflow |-> $past(conv_valid, 2) && !$past(conv_ready, 2))
    else $error("overflow without a refused word");
endmodule
bind asr_readout asr_readout_properties #(.RES_W(RES_W)) u_props (
  .mclk               (mclk),
  .resetn             (resetn),
  .sclk_pin           (sclk_pin),
  .sel_n_pin          (sel_n_pin),
  .serial_out_line    (serial_out_line),
  .serial_out_line_oe (serial_out_line_oe),
  .conv_data          (conv_data),
  .conv_valid         (conv_valid),
  .conv_ready         (conv_ready),
  .conv_start         (conv_start),
  .conv_abort         (conv_abort),
  .hold               (hold),
  .power_down         (power_down),
  .fifo_overflow      (fifo_overflow)
);

//--- sim/asr_host_model.sv
// Purpose: Host serial master for the link
// Assumes: Clock idles high, host samples before each fall and at each rise
// Notes:   Clock stands still between frames
`timescale 1ns/1ps
module asr_host_model (
  // Link
  output logic     sclk_pin,
  output logic     sel_n_pin,
  input wire logic serial_out_line,
  input wire logic serial_out_line_oe,
  input wire logic hold
);
  logic [23:0] bits;
  logic [23:0] rbits;
  logic [23:0] holds;
  logic        oe_end;
  // A released line reads as the inverse of its last level, so a late sample shows
  wire line = serial_out_line_oe ? serial_out_line : ~serial_out_line;
  initial begin
    sclk_pin = 1'b1;
    sel_n_pin = 1'b1;
  end
  task automatic frame(input int n);
    sel_n_pin <= 1'b0;
    #48;
    for (int i = 0; i < n; i++) begin
      #24;
      bits[23-i] = line;
      holds[23-i] = hold;
      sclk_pin <= 1'b0;
      #24;
      rbits[23-i] = line;
      sclk_pin <= 1'b1;
    end
    #24;
    oe_end = serial_out_line_oe;
    sel_n_pin <= 1'b1;
    #200;
  endtask
endmodule

//--- sim/asr_readout_tb.sv
// Purpose: Self-checking bench for the readout block
// Assumes: FIFO preloaded before frames
// Notes:   Host captures before each fall and again at each rise
`timescale 1ns/1ps
module asr_readout_tb;
  import asr_pkg::*;
  logic mclk, resetn, sclk_pin, sel_n_pin, serial_out_line, serial_out_line_oe;
  logic conv_valid, conv_ready, conv_start, conv_abort, hold, power_down, fifo_overflow;
  logic [15:0] conv_data;
  int errors, total_checks, aborts, starts;
  asr_readout u_dut (
    .mclk               (mclk),
    .resetn             (resetn),
    .sclk_pin           (sclk_pin),
    .sel_n_pin          (sel_n_pin),
    .serial_out_line    (serial_out_line),
    .serial_out_line_oe (serial_out_line_oe),
    .conv_data          (conv_data),
    .conv_valid         (conv_valid),
    .conv_ready         (conv_ready),
    .conv_start         (conv_start),
    .conv_abort         (conv_abort),
    .hold               (hold),
    .power_down         (power_down),
    .fifo_overflow      (fifo_overflow)
  );
  asr_host_model u_host (
    .sclk_pin           (sclk_pin),
    .sel_n_pin          (sel_n_pin),
    .serial_out_line    (serial_out_line),
    .serial_out_line_oe (serial_out_line_oe),
    .hold               (hold)
  );
  function automatic logic [15:0] wv(input int i);
    return 16'h8001 ^ 16'(i * 16'h1357);
  endfunction
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge mclk) if (conv_abort === 1'b1) aborts++;
  always @(posedge mclk) if (conv_start === 1'b1) starts++;
  task automatic t_fill;
    int k;
    k = 0;
    conv_valid <= 1'b1;
    conv_data <= wv(0);
    repeat (20) begin
      @(negedge mclk);
      if (conv_ready === 1'b1) begin
        @(posedge mclk);
        k++;
        conv_data <= wv(k);
      end
    end
    cmp(24'(k), 24'(FIFO_DEPTH));
    cmp(24'(fifo_overflow), 24'h1);
    @(posedge mclk);
    conv_valid <= 1'b0;
  endtask
  task automatic t_full24;
    int s;
    s = starts;
    u_host.frame(24);
    cmp(u_host.bits, {4'h0, wv(0), 4'h0});
    cmp(24'(u_host.rbits[23:1]), {4'h0, wv(0), 4'h0});
    cmp(24'({u_host.holds[23], u_host.holds[7], u_host.holds[4]}), 24'h6);
    cmp(24'(u_host.oe_end), 24'h0);
    cmp(24'(starts - s), 24'h1);
    cmp(24'(conv_ready), 24'h1);
  endtask
  task automatic t_short20;
    int a;
    a = aborts;
    u_host.frame(20);
    cmp(24'(u_host.bits[23:4]), {8'h0, wv(1)});
    cmp(24'(aborts - a), 24'h0);
    cmp(24'(u_host.oe_end), 24'h1);
  endtask
  task automatic t_abort12;
    int a;
    a = aborts;
    u_host.frame(12);
    cmp(24'({aborts - a == 1, power_down, serial_out_line_oe}), 24'h4);
  endtask
  task automatic t_glitch;
    u_host.frame(1);
    cmp(24'(power_down), 24'h0);
  endtask
  task automatic t_power;
    int s;
    u_host.frame(8);
    cmp(24'(power_down), 24'h1);
    s = starts;
    u_host.frame(5);
    cmp(24'(power_down), 24'h1);
    u_host.frame(20);
    cmp(24'(power_down), 24'h0);
    cmp(24'(starts - s), 24'h0);
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #100000;
    errors++;
    complete_run;
  end
  initial begin
    resetn = 1'b0;
    conv_valid = 1'b0;
    conv_data = '0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    repeat (5) @(posedge mclk);
    t_fill;
    t_full24;
    t_short20;
    t_abort12;
    t_glitch;
    t_power;
    complete_run;
  end
endmodule
